// ### monitor_defs.vh
`ifndef MONITOR_DEFS_VH
`define MONITOR_DEFS_VH

// register indices; byte address is four times the index
`define IDX_MONITOR_ENABLE     16'h2106
`define IDX_MONITOR_WORD0_HIGH 16'h210d
`define IDX_MONITOR_WORD0_LOW  16'h210e
`define IDX_MONITOR_WORD1      16'h210f
`define IDX_MONITOR_WORD2      16'h2110
`define IDX_MONITOR_WORD3      16'h2111

// field positions
`define ENABLE_BIT             1

// reset values
`define RST_ENABLE             1'b0
`define RST_WORD               8'h00
`define RST_WORD0_HIGH         2'h0

// timing
`define BIT_PERIOD_NS          64
`define CLK_PERIOD_NS          8
`define BIT_CYCLES             (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define WORD_BITS              10
`define FRAME_WORDS            4

`endif

// ### bit_rate_divider.v
`timescale 1ns/1ns
module bit_rate_divider #(
    parameter DIV_CYCLES = 8,
    parameter CNT_W      = 8
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // control
    input  wire             run_i,
    // enable pulse
    output reg              tick_o
);
    reg [CNT_W-1:0] count;

    // counter restarts while stopped so the first bit has a full period
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (count == DIV_CYCLES[CNT_W-1:0] - 1'b1) begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count  <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ### realtime_monitor_serial_out.v
`timescale 1ns/1ns
`include "monitor_defs.vh"
module realtime_monitor_serial_out #(
    parameter BIT_CYCLES = `BIT_CYCLES
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [17:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // monitor output
    output reg         monitor_serial_pin_o,
    output reg         frame_start_o
);
    reg        monitor_enable;
    reg [1:0]  monitor_word0_high;
    reg [7:0]  monitor_word0_low;
    reg [7:0]  monitor_word1;
    reg [7:0]  monitor_word2;
    reg [7:0]  monitor_word3;

    reg [9:0]  shifter;
    reg [3:0]  bit_cnt;
    reg [1:0]  word_cnt;
    reg        running;
    wire       tick;
    wire [9:0] cur_word;

    wire [15:0] idx = adr_i[17:2];
    wire        req = cyc_i && stb_i && !ack_o;
    wire        wr  = req && we_i && sel_i[0];

    // widen an 8-bit word to the 10-bit slot with zero upper bits
    function [9:0] widen;
        input [7:0] w;
        begin
            widen = {2'b00, w};
        end
    endfunction

    function [9:0] word_sel;
        input [1:0] n;
        begin
            case (n)
                2'd0:    word_sel = {monitor_word0_high,
                                     monitor_word0_low};
                2'd1:    word_sel = widen(monitor_word1);
                2'd2:    word_sel = widen(monitor_word2);
                2'd3:    word_sel = widen(monitor_word3);
                default: word_sel = 10'h000;
            endcase
        end
    endfunction

    // a function result cannot be part-selected, so it goes through a net
    assign cur_word = word_sel(word_cnt);

    bit_rate_divider #(
        .DIV_CYCLES (BIT_CYCLES),
        .CNT_W      (8)
    ) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (monitor_enable),
        .tick_o (tick)
    );

    // registers: single-cycle ack, unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o              <= 1'b0;
            dat_o              <= 32'h00000000;
            monitor_enable     <= `RST_ENABLE;
            monitor_word0_high <= `RST_WORD0_HIGH;
            monitor_word0_low  <= `RST_WORD;
            monitor_word1      <= `RST_WORD;
            monitor_word2      <= `RST_WORD;
            monitor_word3      <= `RST_WORD;
        end else begin
            ack_o <= req;
            dat_o <= 32'h00000000;
            if (wr) begin
                case (idx)
                    `IDX_MONITOR_ENABLE:
                        monitor_enable <= dat_i[`ENABLE_BIT];
                    `IDX_MONITOR_WORD0_HIGH:
                        monitor_word0_high <= dat_i[1:0];
                    `IDX_MONITOR_WORD0_LOW: monitor_word0_low <= dat_i[7:0];
                    `IDX_MONITOR_WORD1:     monitor_word1 <= dat_i[7:0];
                    `IDX_MONITOR_WORD2:     monitor_word2 <= dat_i[7:0];
                    `IDX_MONITOR_WORD3:     monitor_word3 <= dat_i[7:0];
                    default: ;
                endcase
            end
            if (req && !we_i) begin
                case (idx)
                    `IDX_MONITOR_ENABLE:
                        dat_o[`ENABLE_BIT] <= monitor_enable;
                    `IDX_MONITOR_WORD0_HIGH:
                        dat_o[1:0] <= monitor_word0_high;
                    `IDX_MONITOR_WORD0_LOW: dat_o[7:0] <= monitor_word0_low;
                    `IDX_MONITOR_WORD1:     dat_o[7:0] <= monitor_word1;
                    `IDX_MONITOR_WORD2:     dat_o[7:0] <= monitor_word2;
                    `IDX_MONITOR_WORD3:     dat_o[7:0] <= monitor_word3;
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // serialiser: words sampled at each word boundary, so a write
    // lands at the next word without tearing the one in flight
    always @(posedge clk_i) begin
        if (rst_i || !monitor_enable) begin
            monitor_serial_pin_o <= 1'b0;
            frame_start_o        <= 1'b0;
            shifter              <= 10'h000;
            bit_cnt              <= 4'd0;
            word_cnt             <= 2'd0;
            running              <= 1'b0;
        end else if (tick) begin
            frame_start_o <= 1'b0;
            if (!running || bit_cnt == 4'd0) begin
                // load next word, emit its msb
                shifter <= {cur_word[8:0], 1'b0};
                monitor_serial_pin_o <= cur_word[9];
                frame_start_o <= (word_cnt == 2'd0);
                bit_cnt  <= 4'd9;
                word_cnt <= word_cnt + 2'd1;
                running  <= 1'b1;
            end else begin
                monitor_serial_pin_o <= shifter[9];
                shifter <= {shifter[8:0], 1'b0};
                bit_cnt <= bit_cnt - 4'd1;
            end
        end
    end
endmodule

// ### realtime_monitor_serial_out_checker.sv
`timescale 1ns/1ns
`include "monitor_defs.vh"
module realtime_monitor_serial_out_checker #(parameter BIT_CYCLES = 2) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [17:0] adr_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    input wire        monitor_serial_pin_o,
    input wire        frame_start_o
);
    localparam int W1 = 10 * BIT_CYCLES, L1 = W1 / 5 - 1, FR = 4 * W1;
    logic en;
    // shadow taken at the request edge, never later than the design's
    always @(posedge clk_i)
        if (rst_i) en <= 1'b0;
        else if (cyc_i && stb_i && we_i && !ack_o
                 && adr_i == {`IDX_MONITOR_ENABLE, 2'h0}) en <= dat_i[1];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence upper_zero;
        !monitor_serial_pin_o ##[L1:L1] !monitor_serial_pin_o;
    endsequence
    a_pin_low_off: assert property (!en && !$past(en)
        |-> !monitor_serial_pin_o) else $error("pin active while off");
    a_start_needs_en: assert property ($rose(frame_start_o) |-> en)
        else $error("frame while off");
    a_frame_repeat: assert property (disable iff (rst_i || !en)
        $rose(frame_start_o) |-> ##[FR:FR] $rose(frame_start_o))
        else $error("bad frame length");
    a_word1_upper: assert property (disable iff (rst_i || !en)
        $rose(frame_start_o) |-> ##[W1:W1] upper_zero)
        else $error("word1 upper bits set");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("late ack");
endmodule

// ### monitor_fixture.sv
`timescale 1ns/1ns
module monitor_fixture #(parameter B = 2) (
    input  wire         clk_i,
    input  wire         pin_i,
    input  wire         start_i,
    output logic [39:0] frame_o,
    output logic        done_o
);
    int   k    = 0;
    logic prev = 1'b0;
    // one sample per bit, on its first clock, counted from the marker
    always @(posedge clk_i) begin
        prev <= start_i;
        k <= (start_i && !prev) ? 1 : (k > 0 && k < 40 * B) ? k + 1 : k;
        if ((start_i && !prev) || (k > 0 && k % B == 0 && k < 40 * B))
            frame_o <= {frame_o[38:0], pin_i};
        done_o <= k == 40 * B - 1;
    end
endmodule

// ### realtime_monitor_serial_out_tb_top.sv
`timescale 1ns/1ns
`include "monitor_defs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    n_mismatch++; $display("[FAIL] %0t mismatch", $time); end end
module realtime_monitor_serial_out_tb_top;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [17:0] adr_i = 0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 0, rd;
    logic [9:0]  w1 = 10'hc3;
    wire  [31:0] dat_o;
    wire  [39:0] frame;
    wire         ack_o, monitor_serial_pin_o, frame_start_o, done;
    int          n_mismatch = 0, checks_done = 0, ticks = 0;
    initial forever #4 clk_i = ~clk_i;
    realtime_monitor_serial_out #(.BIT_CYCLES(2)) DUT (.*);
    monitor_fixture #(.B(2)) fix (.clk_i, .pin_i(monitor_serial_pin_o),
        .start_i(frame_start_o), .frame_o(frame), .done_o(done));
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i)
        if (++ticks == 5000) begin
            n_mismatch++;
            summarize;
        end
    task wb(input logic w, input logic [15:0] i, input logic [31:0] d);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, i, 2'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(1, 16'h2107, 32'hff);
        // the sweep also reads the unmapped holes, which must stay 0
        for (int a = 'h2106; a <= 'h2111; a++) begin
            wb(0, 16'(a), 0);
            `CHK(rd, 32'h0)
        end
        wb(1, `IDX_MONITOR_WORD0_HIGH, 32'h6);
        wb(0, `IDX_MONITOR_WORD0_HIGH, 0);
        `CHK(rd, 32'h2)
        wb(1, `IDX_MONITOR_WORD0_LOW, 32'ha5);
        wb(1, `IDX_MONITOR_WORD1, 32'hc3);
        wb(1, `IDX_MONITOR_WORD2, 32'h81);
        wb(1, `IDX_MONITOR_WORD3, 32'hff);
        for (int n = 0; n < 2; n++) begin
            wb(1, `IDX_MONITOR_ENABLE, 32'h2);
            @(posedge frame_start_o);
            @(posedge done);
            `CHK(frame, {10'h2a5, w1, 20'h204ff})
            wb(1, `IDX_MONITOR_ENABLE, 0);
            w1 = 10'h3c;
            wb(1, `IDX_MONITOR_WORD1, 32'(w1));
            repeat (50) @(posedge clk_i);
            `CHK(monitor_serial_pin_o, 1'b0)
        end
        summarize;
    end
endmodule
bind realtime_monitor_serial_out realtime_monitor_serial_out_checker
    #(.BIT_CYCLES(BIT_CYCLES)) chk (.*);
